// ===== logic/lpm_pkg.sv
// constants and types for the low power mode controller
package lpm_pkg;
	// register byte addresses
	localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h38;
	localparam logic [7:0] OSC_PAUSE_CONTROL_ADDR = 8'h3C;
	// sleep_control fields
	localparam int SLP_REQ_BIT = 7;
	localparam int WAKE_METHOD_BIT = 6;
	localparam int SLP_RSVD_BIT = 5;
	localparam int PIN_HOLD_BIT = 4;
	localparam int SETTLE_LO_BIT = 2;
	// osc_and_pause_control fields
	localparam int OSC_ON_BIT = 7;
	localparam int CPU_PAUSE_BIT = 2;
	localparam int GATE_BIT = 4;
	localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
	localparam logic [7:0] OSC_PAUSE_RST = 8'h80;
	// settle counts in high-frequency clocks
	localparam logic [17:0] SETTLE_CNT_00 = 18'h3_0000;
	localparam logic [17:0] SETTLE_CNT_01 = 18'h1_0000;
	localparam logic [17:0] SETTLE_CNT_10 = 18'h0_C000;
	localparam logic [17:0] SETTLE_CNT_11 = 18'h0_4000;
	localparam logic [17:0] DIV_ZERO = 18'h0_0000;
	localparam logic [15:0] PC_SKIP = 16'h0002;

	typedef enum {
		ST_RUN,
		ST_SLEEP,
		ST_SETTLE,
		ST_CPU_PAUSE,
		ST_GATED
	} lpm_mode_e;

	typedef struct packed {
		logic cpuHalt;
		logic wdtHalt;
		logic periphHalt;
		logic oscOn;
		logic pinHiZ;
		logic inputsZero;
		logic wakePinHiZ;
	} lpm_ctl_s;
endpackage

// ===== logic/lpm_low_power_mode_control.sv
// low power mode controller with AHB-Lite register slave
//Contract
//- setting sleep request bit seven stops oscillator and halts everything
//- deep sleep keeps memory, registers, status word and port latches
//- sleep entry clears prescaler and divider; restart begins from zero
//- during sleep program counter holds request address plus two
//- wake method bit: zero edge release, one level release
//- level release leaves sleep while wake pin is high
//- level release sleep request with pin high goes straight to warm-up
//- output hold bit zero floats ports in sleep, one keeps driving
//- with hold zero in sleep, port inputs read as zero
//- wake pin port floats in sleep regardless of hold bit
//- settle field selects 3*2^16, 2^16, 3*2^14 or 2^14 clocks
//- release restarts oscillator, halts for settle, then resumes after request
//- reset pin low ends sleep at once with a normal reset
//- bits one and zero of sleep control read undefined
//- oscillator enable one runs oscillator; clearing it resets the device
//- cpu pause bit stops cpu and watchdog; cleared on release
//- clock gate bit enters gated pause; cleared on release
//- write zero to bits six, five; bits three, one, zero undefined
//- gated pause return timed by asynchronous clock, may be shorter
//- gated pause ends on falling edge of selected tick source clock
//- cpu pause resumes on enabled interrupt, restores previous mode
`timescale 1ns/100ps
`default_nettype none
module lpm_low_power_mode_control (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic resetPin_n,
	input wire logic wakePin,
	input wire logic tickSrcClk,
	input wire logic irqPending,
	input wire logic [15:0] cpuPc,
	output lpm_pkg::lpm_ctl_s ctl,
	output logic [15:0] heldPc,
	output logic deviceReset,
	output logic [17:0] divCount,
	output logic [2:0] modeState
);
	lpm_pkg::lpm_mode_e mode_r;
	logic [7:0] sleepCtl_r;
	logic [7:0] oscCtl_r;
	logic [17:0] div_r;
	logic [15:0] pc_r;
	logic wakePrev_r;
	logic tickPrev_r;
	logic oscRst_r;
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic [7:0] wd;
	logic [17:0] settleCnt;
	logic rstAll;
	logic wrSleep;
	logic wrOsc;
	logic wakeHit;
	logic tickFall;

	assign rstAll = sys_rst || !resetPin_n || oscRst_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wd = hwdata[7:0];
	assign wrSleep = wrPend_r && wrAddr_r == lpm_pkg::SLEEP_CONTROL_ADDR;
	assign wrOsc = wrPend_r && wrAddr_r == lpm_pkg::OSC_PAUSE_CONTROL_ADDR;
	assign wakeHit = sleepCtl_r[lpm_pkg::WAKE_METHOD_BIT] ? wakePin
		: (wakePin && !wakePrev_r);
	assign tickFall = tickPrev_r && !tickSrcClk;

	always_comb begin
		case (sleepCtl_r[lpm_pkg::SETTLE_LO_BIT +: 2])
			2'b00: settleCnt = lpm_pkg::SETTLE_CNT_00;
			2'b01: settleCnt = lpm_pkg::SETTLE_CNT_01;
			2'b10: settleCnt = lpm_pkg::SETTLE_CNT_10;
			default: settleCnt = lpm_pkg::SETTLE_CNT_11;
		endcase
	end

	// address phase capture for writes
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= hsel && hready && htrans[1] && hwrite;
			wrAddr_r <= haddr[7:0];
		end
	end

	// read data registered in address phase; unmapped reads give zero
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && hready && htrans[1] && !hwrite) begin
			// low bits undefined, shown as zero
			if (haddr[7:0] == lpm_pkg::SLEEP_CONTROL_ADDR)
				hrdata <= {24'h00_0000, sleepCtl_r[7:2], 2'b00};
			else if (haddr[7:0] == lpm_pkg::OSC_PAUSE_CONTROL_ADDR)
				hrdata <= {24'h00_0000, oscCtl_r & 8'h94};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// oscillator-off reset pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oscRst_r <= 1'b0;
		end else begin
			oscRst_r <= wrOsc && !wd[lpm_pkg::OSC_ON_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rstAll) begin
			wakePrev_r <= 1'b0;
			tickPrev_r <= 1'b0;
		end else begin
			wakePrev_r <= wakePin;
			tickPrev_r <= tickSrcClk;
		end
	end

	// mode sequencer and register bits with hardware clears
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			mode_r <= lpm_pkg::ST_RUN;
			sleepCtl_r <= lpm_pkg::SLEEP_CONTROL_RST;
			oscCtl_r <= lpm_pkg::OSC_PAUSE_RST;
		end else begin
			case (mode_r)
				lpm_pkg::ST_RUN: begin
					if (wrSleep) begin
						sleepCtl_r <= wd & 8'hDC;
						if (wd[lpm_pkg::SLP_REQ_BIT]) begin
							if (wd[lpm_pkg::WAKE_METHOD_BIT] && wakePin)
								mode_r <= lpm_pkg::ST_SETTLE;
							else
								mode_r <= lpm_pkg::ST_SLEEP;
						end
					end else if (wrOsc) begin
						oscCtl_r <= wd & 8'h94;
						if (wd[lpm_pkg::CPU_PAUSE_BIT])
							mode_r <= lpm_pkg::ST_CPU_PAUSE;
						else if (wd[lpm_pkg::GATE_BIT])
							mode_r <= lpm_pkg::ST_GATED;
					end
				end
				lpm_pkg::ST_SLEEP: begin
					if (wakeHit)
						mode_r <= lpm_pkg::ST_SETTLE;
				end
				lpm_pkg::ST_SETTLE: begin
					if (div_r >= settleCnt - 18'h0_0001) begin
						mode_r <= lpm_pkg::ST_RUN;
						sleepCtl_r[lpm_pkg::SLP_REQ_BIT] <= 1'b0;
					end
				end
				lpm_pkg::ST_CPU_PAUSE: begin
					if (irqPending) begin
						mode_r <= lpm_pkg::ST_RUN;
						oscCtl_r[lpm_pkg::CPU_PAUSE_BIT] <= 1'b0;
					end
				end
				lpm_pkg::ST_GATED: begin
					// may end before a full tick period
					if (tickFall) begin
						mode_r <= lpm_pkg::ST_RUN;
						oscCtl_r[lpm_pkg::GATE_BIT] <= 1'b0;
					end
				end
				default: mode_r <= lpm_pkg::ST_RUN;
			endcase
		end
	end

	// timing generator divider
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			div_r <= lpm_pkg::DIV_ZERO;
		end else if (mode_r == lpm_pkg::ST_SETTLE) begin
			div_r <= div_r + 18'h0_0001;
		end else if (mode_r == lpm_pkg::ST_SLEEP) begin
			div_r <= lpm_pkg::DIV_ZERO;
		end else if (mode_r == lpm_pkg::ST_RUN && (wrSleep
			&& wd[lpm_pkg::SLP_REQ_BIT])) begin
			div_r <= lpm_pkg::DIV_ZERO;
		end else if (mode_r != lpm_pkg::ST_GATED) begin
			div_r <= div_r + 18'h0_0001;
		end
	end

	// captured program counter for any pause
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			pc_r <= 16'h0000;
		end else if (mode_r == lpm_pkg::ST_RUN && (wrSleep || wrOsc)) begin
			pc_r <= cpuPc + lpm_pkg::PC_SKIP;
		end
	end

	// control outputs from flip-flops
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			ctl <= '{default: 1'b0, oscOn: 1'b1};
			heldPc <= 16'h0000;
		end else begin
			ctl.cpuHalt <= mode_r != lpm_pkg::ST_RUN;
			ctl.wdtHalt <= mode_r != lpm_pkg::ST_RUN;
			ctl.periphHalt <= mode_r == lpm_pkg::ST_SLEEP
				|| mode_r == lpm_pkg::ST_SETTLE
				|| mode_r == lpm_pkg::ST_GATED;
			ctl.oscOn <= mode_r != lpm_pkg::ST_SLEEP;
			// hold bit chooses float or drive
			ctl.pinHiZ <= mode_r == lpm_pkg::ST_SLEEP
				&& !sleepCtl_r[lpm_pkg::PIN_HOLD_BIT];
			ctl.inputsZero <= mode_r == lpm_pkg::ST_SLEEP
				&& !sleepCtl_r[lpm_pkg::PIN_HOLD_BIT];
			ctl.wakePinHiZ <= mode_r == lpm_pkg::ST_SLEEP;
			heldPc <= pc_r;
		end
	end

	assign deviceReset = rstAll;
	assign divCount = div_r;
	assign modeState = 3'(mode_r);

	a_sleep_osc_off: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP |=> !ctl.oscOn)
		else $error("oscillator running in sleep");
	a_sleep_div_zero: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && $past(mode_r) == lpm_pkg::ST_SLEEP
		|-> div_r == lpm_pkg::DIV_ZERO)
		else $error("divider not cleared in sleep");
	a_level_skip: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_RUN && wrSleep && wd[7] && wd[6] && wakePin
		|=> mode_r == lpm_pkg::ST_SETTLE)
		else $error("level request with pin high did not skip sleep");
	a_level_wake: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && sleepCtl_r[6] && wakePin
		|=> mode_r == lpm_pkg::ST_SETTLE)
		else $error("level wake missed");
	a_wake_pin_float: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP |=> ctl.wakePinHiZ)
		else $error("wake pin driven in sleep");
	a_hold_drive: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && sleepCtl_r[4] |=> !ctl.pinHiZ)
		else $error("held pins floated");
	a_pause_clear: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_CPU_PAUSE && irqPending
		|=> !oscCtl_r[2] && mode_r == lpm_pkg::ST_RUN)
		else $error("pause bit not cleared on release");
	a_gate_clear: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_GATED && tickFall
		|=> !oscCtl_r[4] && mode_r == lpm_pkg::ST_RUN)
		else $error("gate bit not cleared on release");
	a_settle_short: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SETTLE && sleepCtl_r[3:2] == 2'b11
		&& div_r == 18'h0_3FFF |=> mode_r == lpm_pkg::ST_RUN)
		else $error("shortest settle count wrong");
	a_osc_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		wrOsc && !wd[7] |=> deviceReset)
		else $error("oscillator clear did not reset");

	a_sleep_entry: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_RUN && wrSleep && wd[7]
		&& !(wd[6] && wakePin) |=> mode_r == lpm_pkg::ST_SLEEP)
		else $error("sleep request not taken");

	a_edge_wake: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && !sleepCtl_r[6] && wakePin
		&& !wakePrev_r |=> mode_r == lpm_pkg::ST_SETTLE)
		else $error("edge wake missed");

	a_edge_stay: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && !sleepCtl_r[6] && !wakePin
		|=> mode_r == lpm_pkg::ST_SLEEP)
		else $error("edge sleep left without a rising pin");

	a_settle_start: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SETTLE && $past(mode_r) != lpm_pkg::ST_SETTLE
		|-> div_r == lpm_pkg::DIV_ZERO)
		else $error("warm-up did not start from zero");

	a_settle_hold: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SETTLE && div_r < settleCnt - 18'h0_0001
		|=> mode_r == lpm_pkg::ST_SETTLE)
		else $error("warm-up ended early");

	a_settle_halt: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SETTLE
		|=> ctl.cpuHalt && ctl.periphHalt && ctl.oscOn)
		else $error("core ran during warm-up");

	a_pc_held: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && $past(mode_r) == lpm_pkg::ST_SLEEP
		|-> heldPc == pc_r)
		else $error("held program counter moved in sleep");

	a_inputs_zero: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_SLEEP && !sleepCtl_r[4]
		|=> ctl.inputsZero)
		else $error("inputs not forced low in sleep");

	a_pause_entry: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_RUN && wrOsc && wd[7] && wd[2]
		|=> mode_r == lpm_pkg::ST_CPU_PAUSE)
		else $error("cpu pause not entered");

	a_pause_halts: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_CPU_PAUSE
		|=> ctl.cpuHalt && ctl.wdtHalt && !ctl.periphHalt)
		else $error("cpu pause halts wrong units");

	a_gate_entry: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_RUN && wrOsc && wd[7] && !wd[2] && wd[4]
		|=> mode_r == lpm_pkg::ST_GATED)
		else $error("gated pause not entered");

	a_gated_halts: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_GATED |=> ctl.periphHalt)
		else $error("peripherals clocked in gated pause");

	a_pin_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		!resetPin_n |=> mode_r == lpm_pkg::ST_RUN)
		else $error("reset pin did not return to run");

	a_read_low: assert property (@(posedge mclk) disable iff (sys_rst)
		hsel && hready && htrans[1] && !hwrite
		&& haddr[7:0] == lpm_pkg::SLEEP_CONTROL_ADDR
		|=> hrdata[1:0] == 2'b00)
		else $error("undefined sleep bits not read as zero");

	a_rsvd_zero: assert property (@(posedge mclk) disable iff (rstAll)
		mode_r == lpm_pkg::ST_RUN && (wrSleep || wrOsc)
		|=> !sleepCtl_r[5] && oscCtl_r[6:5] == 2'b00)
		else $error("reserved control bits set");
endmodule
`default_nettype wire

// ===== verification/lpm_far_side.sv
// far-side model: wake pin driver, reset source and tick source clock
`timescale 1ns/100ps
`default_nettype none
module lpm_far_side (
	input wire logic mclk,
	input wire logic wakeReq,
	input wire logic rstReq,
	input wire logic tickRun,
	output logic wakePin,
	output logic resetPin_n,
	output logic tickSrcClk
);
	logic wake_r = 1'b0;
	logic rst_r = 1'b0;
	logic [2:0] tickDiv_r = 3'h0;
	always_ff @(posedge mclk) begin
		wake_r <= wakeReq;
		rst_r <= rstReq;
	end
	// tick clock only on demand, idles high so no stray fall
	always_ff @(posedge mclk) begin
		tickDiv_r <= tickRun ? tickDiv_r + 3'h1 : 3'h0;
	end
	assign wakePin = wake_r;
	assign resetPin_n = !rst_r;
	assign tickSrcClk = !tickDiv_r[2];
endmodule
`default_nettype wire

// ===== verification/lpm_low_power_mode_control_tb.sv
// self-checking bench for the low power mode controller
`timescale 1ns/100ps
`default_nettype none
module lpm_low_power_mode_control_tb;
	logic mclk, sysRst, hsel, hwrite, wakeReq, rstReq, tickRun, irqPending;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, modeState;
	logic [15:0] cpuPc, heldPc;
	logic [17:0] divCount;
	logic hreadyout, hresp, deviceReset, wakePin, resetPin_n, tickSrcClk;
	lpm_pkg::lpm_ctl_s ctl;
	int miscompares = 0;
	int comparisons = 0;
	int n;
	bit rdPend = 0;
	string nmQ[$];
	logic [31:0] expQ[$];
	logic [7:0] v;

	lpm_low_power_mode_control dut_u (.mclk(mclk), .sys_rst(sysRst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .resetPin_n(resetPin_n),
		.wakePin(wakePin), .tickSrcClk(tickSrcClk), .irqPending(irqPending),
		.cpuPc(cpuPc), .ctl(ctl), .heldPc(heldPc), .deviceReset(deviceReset),
		.divCount(divCount), .modeState(modeState));
	lpm_far_side far_u (.mclk(mclk), .wakeReq(wakeReq), .rstReq(rstReq),
		.tickRun(tickRun), .wakePin(wakePin), .resetPin_n(resetPin_n),
		.tickSrcClk(tickSrcClk));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		nmQ.push_back(nm);
		expQ.push_back(e);
		xfer(1'b0, a, 32'h0000_0000);
	endtask

	task automatic waitn(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic pin_reset;
		rstReq <= 1'b1;
		waitn(3);
		chk("pin reset", 1, deviceReset);
		rstReq <= 1'b0;
		waitn(3);
		chk("mode after reset", 0, modeState);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// read data is judged at the edge that ends its data phase
	always @(posedge mclk) begin
		if (rdPend && expQ.size() > 0) begin
			chk(nmQ.pop_front(), expQ.pop_front(), hrdata);
		end
		rdPend <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h3b8d_1854));
		{hsel, hwrite, wakeReq, rstReq, tickRun, irqPending} = 6'h00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'h0;
		hsize = 3'h2;
		sysRst = 1'b1;
		cpuPc = 16'($urandom);
		repeat (10) @(posedge mclk);
		sysRst <= 1'b0;
		rd(8'h38, 32'h0000_0000, "sleep reset");
		rd(8'h3C, 32'h0000_0080, "osc reset");
		rd(8'h40, 32'h0000_0000, "unmapped");
		chk("resp", 0, hresp);
		v = 8'($urandom) & 8'h5F;
		xfer(1'b1, 8'h38, {24'h00_0000, v});
		rd(8'h38, {24'h00_0000, v & 8'h5C}, "sleep rw");
		$display("test registers done");
		xfer(1'b1, 8'h38, 32'h0000_008C);
		waitn(3);
		chk("sleep mode", 1, modeState);
		chk("osc off", 0, ctl.oscOn);
		chk("div clear", 0, divCount);
		chk("held pc", 16'(cpuPc + 16'h0002), heldPc);
		chk("pins float", 1, ctl.pinHiZ);
		chk("inputs zero", 1, ctl.inputsZero);
		chk("wake float", 1, ctl.wakePinHiZ);
		wakeReq <= 1'b1;
		n = 0;
		while (modeState !== 3'h0 && n < 20000) begin
			waitn(1);
			if (modeState === 3'h2) n++;
		end
		chk("settle count", 32'h0000_4000, n);
		chk("osc back", 1, ctl.oscOn);
		$display("test edge sleep done");
		for (int c = 0; c < 3; c++) begin
			wakeReq <= 1'b0;
			xfer(1'b1, 8'h38, {24'h00_0000, 8'hD0 | 8'(c << 2)});
			waitn(3);
			chk("level sleep", 1, modeState);
			chk("pins driven", 0, ctl.pinHiZ);
			chk("wake float", 1, ctl.wakePinHiZ);
			wakeReq <= 1'b1;
			waitn(4);
			chk("level wake", 2, modeState);
			pin_reset();
		end
		xfer(1'b1, 8'h38, 32'h0000_00CC);
		waitn(1);
		chk("sleep skipped", 2, modeState);
		pin_reset();
		rd(8'h38, 32'h0000_0000, "sleep after reset");
		$display("test level sleep done");
		// pause and gate in separate writes
		xfer(1'b1, 8'h3C, 32'h0000_0084);
		waitn(3);
		chk("pause mode", 3, modeState);
		chk("cpu halt", 1, ctl.cpuHalt);
		chk("wdt halt", 1, ctl.wdtHalt);
		chk("periph run", 0, ctl.periphHalt);
		irqPending <= 1'b1;
		waitn(3);
		chk("pause end", 0, modeState);
		irqPending <= 1'b0;
		rd(8'h3C, 32'h0000_0080, "pause cleared");
		xfer(1'b1, 8'h3C, 32'h0000_0090);
		waitn(3);
		chk("gated mode", 4, modeState);
		chk("periph halt", 1, ctl.periphHalt);
		tickRun <= 1'b1;
		waitn(12);
		chk("gated end", 0, modeState);
		tickRun <= 1'b0;
		rd(8'h3C, 32'h0000_0080, "gate cleared");
		$display("test pause done");
		xfer(1'b1, 8'h38, 32'h0000_005C);
		xfer(1'b1, 8'h3C, 32'h0000_0000);
		waitn(0);
		n = 0;
		repeat (4) begin
			if (deviceReset === 1'b1) n++;
			waitn(1);
		end
		chk("osc reset pulse", 1, n);
		rd(8'h38, 32'h0000_0000, "sleep after osc");
		rd(8'h3C, 32'h0000_0080, "osc after osc");
		waitn(2);
		$display("test osc clear done");
		wrap_up();
	end
endmodule
`default_nettype wire
